// ### rtl/dac_input_update_control.sv
// Operation
// - Enable bit set lets the converter convert; clear disables it.
// - Auto-trigger set: update on trigger edge; clear: on high write.
// - Three-bit select picks one of eight trigger sources.
// - Trigger is the source flag's rising edge, interrupt masks ignored.
// - A trigger level still high after a conversion starts nothing.
// - Trigger edges during a conversion are ignored, never queued.
// - Source flag must be cleared to rise again for the next trigger.
// - Left adjust: high holds bits 9..2, low bits 7..6 hold 1..0.
// - Left-adjust change takes effect at next high register write.
// - Output enable drives result to the output pin, else internal.
// - Low write blocks any update until the high write follows.
// - Converted value comes from a hidden shadow register.
// - Manual mode: high write loads shadow from high and low.
// - Auto mode: trigger loads shadow unless a low write still awaits its high write.
// - Input value is ten bits across high and low registers.
// - Comparator flags set on configured event, cleared by writing one.
//
// The register addresses and the APB register port were left to the implementer.
module dac_input_update_control (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [dac_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] comparator_out,
   input wire logic ext_int0_flag,
   input wire logic timer0_compare_flag,
   input wire logic timer0_overflow_flag,
   input wire logic timer1_compare_b_flag,
   input wire logic timer1_overflow_flag,
   input wire logic timer1_capture_flag,
   output logic [dac_pkg::DATA_W-1:0] converter_value,
   output logic converter_enable,
   output logic analog_output_pin_enable,
   output logic conversion_busy
);
   import dac_pkg::*;

   reg_bus_if rb ();

   logic [7:0] converter_control;
   logic [7:0] converter_input_high;
   logic [7:0] converter_input_low;
   logic [1:0] cmp_flag;
   logic [3:0] cmp_mode;
   logic low_pending;
   logic latched_left_adjust;
   logic [DATA_W-1:0] shadow;
   conv_state_t state, next_state;
   logic [7:0] count, next_count;
   logic [1:0] cmp_event;
   logic trig_pulse, trig_level;

   function automatic logic [DATA_W-1:0] compose(input logic la,
      input logic [7:0] hi, input logic [7:0] lo);
      compose = la ? {hi, lo[7:6]} : {hi[1:0], lo};
   endfunction : compose

   apb_reg_slave u_apb (
      .clk(clk),
      .reset(reset),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .rb(rb.bus)
   );

   wire [7:0] sources = {timer1_capture_flag, timer1_overflow_flag,
      timer1_compare_b_flag, timer0_overflow_flag, timer0_compare_flag,
      ext_int0_flag, cmp_flag[1], cmp_flag[0]};

   trigger_edge #(.N_CMP(2)) u_trig (
      .clk(clk),
      .reset(reset),
      .comparator_out(comparator_out),
      .cmp_mode(cmp_mode),
      .sources(sources),
      .trigger_select(converter_control[CTRL_SELECT_LO+:3]),
      .cmp_event(cmp_event),
      .trigger_pulse(trig_pulse),
      .trigger_level(trig_level)
   );

   // Address decode
   wire wr_ctrl = rb.wr && (rb.addr == ADDR_CONTROL);
   wire wr_high = rb.wr && (rb.addr == ADDR_HIGH);
   wire wr_low = rb.wr && (rb.addr == ADDR_LOW);
   wire wr_flags = rb.wr && (rb.addr == ADDR_FLAGS);
   assign rb.hit = (rb.addr == ADDR_CONTROL) || (rb.addr == ADDR_HIGH)
      || (rb.addr == ADDR_LOW) || (rb.addr == ADDR_FLAGS);
   wire [7:0] flags_view = {(state == CONVERTING), 1'b0, cmp_mode, cmp_flag};
   assign rb.rdata = (rb.addr == ADDR_CONTROL) ? converter_control :
      (rb.addr == ADDR_HIGH) ? converter_input_high :
      (rb.addr == ADDR_LOW) ? converter_input_low :
      (rb.addr == ADDR_FLAGS) ? flags_view : 8'h00;

   wire enable = converter_control[CTRL_ENABLE];
   wire auto_mode = converter_control[CTRL_AUTO_TRIGGER];
   wire left_adjust = converter_control[CTRL_LEFT_ADJUST];
   wire idle = (state == IDLE);
   // Edge only while idle: busy edges and held levels start nothing
   wire trig_go = auto_mode && trig_pulse && idle && !low_pending
      && !wr_high;
   wire manual_load = wr_high && !auto_mode;
   wire [DATA_W-1:0] manual_value =
      compose(left_adjust, rb.wdata, converter_input_low);
   wire [DATA_W-1:0] trig_value =
      compose(latched_left_adjust, converter_input_high, converter_input_low);
   wire start = (manual_load || trig_go) && enable;

   always_ff @(posedge clk) begin
      if (reset) begin
         converter_control <= CONTROL_RESET;
         converter_input_high <= HIGH_RESET;
         converter_input_low <= LOW_RESET;
         cmp_mode <= FLAG_MODE_RESET;
      end else begin
         if (wr_ctrl) converter_control <= rb.wdata & CONTROL_MASK;
         if (wr_high) converter_input_high <= rb.wdata;
         if (wr_low) converter_input_low <= rb.wdata;
         if (wr_flags) cmp_mode <= rb.wdata[FLAG_MODE0_LO+:4];
      end
   end

   // Hardware set wins over a write-one clear in the same cycle
   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : g_flag
         always_ff @(posedge clk) begin
            if (reset) begin
               cmp_flag[i] <= 1'b0;
            end else if (cmp_event[i]) begin
               cmp_flag[i] <= 1'b1;
            end else if (wr_flags && rb.wdata[FLAG_CMP0+i]) begin
               cmp_flag[i] <= 1'b0;
            end
         end
      end
   endgenerate

   // Pending low write and shadow update
   always_ff @(posedge clk) begin
      if (reset) begin
         low_pending <= 1'b0;
         latched_left_adjust <= 1'b0;
         shadow <= '0;
      end else begin
         if (wr_high) begin
            low_pending <= 1'b0;
            latched_left_adjust <= left_adjust;
         end else if (wr_low) begin
            low_pending <= 1'b1;
         end
         if (manual_load) shadow <= manual_value;
         else if (trig_go) shadow <= trig_value;
      end
   end

   always_comb begin
      next_state = state;
      next_count = count;
      case (state)
         IDLE: begin
            if (start) begin
               next_state = CONVERTING;
               next_count = CONV_CYCLES - 8'h01;
            end
         end
         CONVERTING: begin
            if (!enable) begin
               next_state = IDLE;
            end else if (manual_load) begin
               next_count = CONV_CYCLES - 8'h01;
            end else if (count == 8'h00) begin
               next_state = IDLE;
            end else begin
               next_count = count - 8'h01;
            end
         end
         default: next_state = IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state <= IDLE;
         count <= 8'h00;
         conversion_busy <= 1'b0;
         converter_enable <= 1'b0;
         analog_output_pin_enable <= 1'b0;
         converter_value <= '0;
      end else begin
         state <= next_state;
         count <= next_count;
         conversion_busy <= (next_state == CONVERTING);
         converter_enable <= enable;
         analog_output_pin_enable <= enable
            && converter_control[CTRL_OUTPUT_ENABLE];
         converter_value <= shadow;
      end
   end

   // Update path
   AST_MANUAL_RIGHT: assert property (
      @(posedge clk) disable iff (reset)
      manual_load && !left_adjust |=>
      shadow == {$past(rb.wdata[1:0]), $past(converter_input_low)})
      else $error("right adjusted manual load wrong");
   AST_MANUAL_LEFT: assert property (
      @(posedge clk) disable iff (reset)
      manual_load && left_adjust |=>
      shadow == {$past(rb.wdata), $past(converter_input_low[7:6])})
      else $error("left adjusted manual load wrong");
   AST_LOW_BLOCKS: assert property (
      @(posedge clk) disable iff (reset)
      low_pending && !wr_high |=> $stable(shadow))
      else $error("shadow changed before high write");
   AST_AUTO_WRITE: assert property (
      @(posedge clk) disable iff (reset)
      wr_high && auto_mode |=> $stable(shadow))
      else $error("high write loaded shadow in auto mode");
   AST_TRIG_LOAD: assert property (
      @(posedge clk) disable iff (reset)
      trig_go && enable |=> shadow == $past(trig_value)
      ##1 converter_value == $past(shadow) && conversion_busy)
      else $error("trigger did not load and convert");
   AST_BUSY_IGNORE: assert property (
      @(posedge clk) disable iff (reset)
      state == CONVERTING && trig_pulse && enable && !manual_load
      && count != 8'h00 |=> count == $past(count) - 8'h01)
      else $error("trigger during conversion restarted it");
   AST_HELD_LEVEL: assert property (
      @(posedge clk) disable iff (reset)
      trig_level && $past(trig_level) |-> !trig_go)
      else $error("held trigger level started conversion");
   AST_DISABLED: assert property (
      @(posedge clk) disable iff (reset)
      !enable |=> !conversion_busy && !converter_enable)
      else $error("converter busy while disabled");
   AST_OUTPUT_PIN: assert property (
      @(posedge clk) disable iff (reset)
      !converter_control[CTRL_OUTPUT_ENABLE] |=> !analog_output_pin_enable)
      else $error("output pin driven while disabled");
   AST_FLAG_SET: assert property (
      @(posedge clk) disable iff (reset)
      cmp_event[0] |=> cmp_flag[0])
      else $error("comparator flag not set");
   AST_CONV_LENGTH: assert property (
      @(posedge clk) disable iff (reset)
      $rose(conversion_busy) && enable && !wr_high && !wr_ctrl
      |-> conversion_busy [*8])
      else $error("conversion ended early");

   // Source selection, one check per kind of source
   AST_CMP0_TRIGGER: assert property (
      @(posedge clk) disable iff (reset)
      $rose(cmp_flag[0]) && $stable(converter_control)
      && converter_control[CTRL_SELECT_LO+:3] == TS_CMP0
      && auto_mode && idle && !low_pending && !wr_high |-> trig_go)
      else $error("comparator flag edge did not trigger");
   AST_EXT0_TRIGGER: assert property (
      @(posedge clk) disable iff (reset)
      $rose(ext_int0_flag) && $stable(converter_control)
      && converter_control[CTRL_SELECT_LO+:3] == TS_EXT0
      && auto_mode && idle && !low_pending && !wr_high |-> trig_go)
      else $error("external flag edge did not trigger");
   AST_CAPTURE_TRIGGER: assert property (
      @(posedge clk) disable iff (reset)
      $rose(timer1_capture_flag) && $stable(converter_control)
      && converter_control[CTRL_SELECT_LO+:3] == TS_T1_CAPTURE
      && auto_mode && idle && !low_pending && !wr_high |-> trig_go)
      else $error("capture flag edge did not trigger");
   AST_BUSY_HOLDS: assert property (
      @(posedge clk) disable iff (reset)
      state == CONVERTING && !manual_load |=> $stable(shadow))
      else $error("shadow changed during conversion");
   AST_PENDING_SET: assert property (
      @(posedge clk) disable iff (reset)
      wr_low && !wr_high |=> low_pending)
      else $error("low write did not block updates");
   AST_LATCH_ADJUST: assert property (
      @(posedge clk) disable iff (reset)
      wr_high |=> latched_left_adjust == $past(left_adjust))
      else $error("left adjust not taken at high write");
   AST_FLAG_CLEAR: assert property (
      @(posedge clk) disable iff (reset)
      wr_flags && rb.wdata[FLAG_CMP1] && !cmp_event[1] |=> !cmp_flag[1])
      else $error("comparator flag not cleared by one");
   AST_ENABLE_ON: assert property (
      @(posedge clk) disable iff (reset)
      enable |=> converter_enable)
      else $error("converter not enabled");
   AST_PIN_ON: assert property (
      @(posedge clk) disable iff (reset)
      enable && converter_control[CTRL_OUTPUT_ENABLE]
      |=> analog_output_pin_enable)
      else $error("output pin not driven");
   AST_SHADOW_LOADS: assert property (
      @(posedge clk) disable iff (reset)
      !manual_load && !trig_go |=> $stable(shadow))
      else $error("shadow changed without a load");

   COV_MANUAL: cover property (@(posedge clk) manual_load && enable);
   COV_TEN_BIT: cover property (@(posedge clk)
      wr_low ##[1:20] wr_high && !auto_mode);
   COV_TRIGGER: cover property (@(posedge clk) trig_go && enable);
   COV_IGNORED: cover property (@(posedge clk)
      trig_pulse && state == CONVERTING);
   COV_HELD_LEVEL: cover property (@(posedge clk)
      !idle ##1 idle && trig_level && auto_mode);
endmodule : dac_input_update_control

// ### rtl/dac_pkg.sv
package dac_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 10;
   localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_HIGH = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_LOW = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_FLAGS = 8'h0c;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] HIGH_RESET = 8'h00;
   localparam logic [7:0] LOW_RESET = 8'h00;
   localparam logic [7:0] CONTROL_MASK = 8'hf7;
   // Control fields
   localparam int CTRL_ENABLE = 0;
   localparam int CTRL_OUTPUT_ENABLE = 1;
   localparam int CTRL_LEFT_ADJUST = 2;
   localparam int CTRL_SELECT_LO = 4;
   localparam int CTRL_AUTO_TRIGGER = 7;
   // Flag register fields
   localparam int FLAG_CMP0 = 0;
   localparam int FLAG_CMP1 = 1;
   localparam int FLAG_MODE0_LO = 2;
   localparam int FLAG_MODE1_LO = 4;
   localparam int FLAG_BUSY = 7;
   localparam logic [3:0] FLAG_MODE_RESET = 4'h0;
   // Comparator event modes
   localparam logic [1:0] CMP_TOGGLE = 2'h0;
   localparam logic [1:0] CMP_FALLING = 2'h2;
   localparam logic [1:0] CMP_RISING = 2'h3;
   // Trigger select codes, also the source bit index
   localparam logic [2:0] TS_CMP0 = 3'h0;
   localparam logic [2:0] TS_CMP1 = 3'h1;
   localparam logic [2:0] TS_EXT0 = 3'h2;
   localparam logic [2:0] TS_T0_COMPARE = 3'h3;
   localparam logic [2:0] TS_T0_OVERFLOW = 3'h4;
   localparam logic [2:0] TS_T1_COMPARE_B = 3'h5;
   localparam logic [2:0] TS_T1_OVERFLOW = 3'h6;
   localparam logic [2:0] TS_T1_CAPTURE = 3'h7;
   // Conversion settling time
   localparam int CLK_PERIOD_NS = 10;
   localparam int CONV_TIME_NS = 1000;
   localparam int CONV_CYCLES_INT =
      (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] CONV_CYCLES = 8'(CONV_CYCLES_INT);
   typedef enum logic {IDLE, CONVERTING} conv_state_t;
endpackage : dac_pkg

// ### rtl/reg_bus_if.sv
interface reg_bus_if;
   logic wr;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic hit;
   modport bus (output wr, addr, wdata, input rdata, hit);
   modport regs (input wr, addr, wdata, output rdata, hit);
endinterface : reg_bus_if

// ### rtl/apb_reg_slave.sv
module apb_reg_slave (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [dac_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   reg_bus_if.bus rb
);
   import dac_pkg::*;
   wire setup_phase = psel && !penable;
   assign rb.addr = paddr;
   assign rb.wdata = pwdata[7:0];
   assign rb.wr = psel && penable && pready && pwrite && rb.hit;

   // Answer is prepared in setup, ready in the first access cycle
   always_ff @(posedge clk) begin
      if (reset) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup_phase) begin
         pready <= 1'b1;
         prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rb.rdata};
         pslverr <= !rb.hit;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end
endmodule : apb_reg_slave

// ### rtl/trigger_edge.sv
module trigger_edge #(
   parameter int N_CMP = 2
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [N_CMP-1:0] comparator_out,
   input wire logic [2*N_CMP-1:0] cmp_mode,
   input wire logic [7:0] sources,
   input wire logic [2:0] trigger_select,
   output logic [N_CMP-1:0] cmp_event,
   output logic trigger_pulse,
   output logic trigger_level
);
   import dac_pkg::*;
   logic [N_CMP-1:0] sync1, sync2, cmp_prev;
   logic [7:0] src_prev;

   genvar i;
   generate
      for (i = 0; i < N_CMP; i++) begin : g_cmp
         logic [1:0] m;
         assign m = cmp_mode[2*i+1:2*i];
         // Two stages before any logic sees the analog output
         always_ff @(posedge clk) begin
            if (reset) begin
               sync1[i] <= 1'b0;
               sync2[i] <= 1'b0;
               cmp_prev[i] <= 1'b0;
            end else begin
               sync1[i] <= comparator_out[i];
               sync2[i] <= sync1[i];
               cmp_prev[i] <= sync2[i];
            end
         end
         assign cmp_event[i] =
            (m == CMP_TOGGLE) ? (sync2[i] ^ cmp_prev[i]) :
            (m == CMP_FALLING) ? (!sync2[i] && cmp_prev[i]) :
            (m == CMP_RISING) ? (sync2[i] && !cmp_prev[i]) : 1'b0;
      end
      for (i = 0; i < 8; i++) begin : g_src
         always_ff @(posedge clk) begin
            if (reset) begin
               src_prev[i] <= 1'b0;
            end else begin
               src_prev[i] <= sources[i];
            end
         end
      end
   endgenerate

   // Only a rising edge of the flag counts, never its level
   assign trigger_level = sources[trigger_select];
   assign trigger_pulse = trigger_level && !src_prev[trigger_select];
endmodule : trigger_edge

// ### tb/trigger_source_model.sv
module trigger_source_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic fire,
   input wire logic [2:0] which,
   input wire logic [7:0] hold,
   output logic [1:0] comparator_out,
   output logic [5:0] flags
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] left;

   // Comparators pulse their output, other sources raise their flag
   always_ff @(posedge clk) begin
      if (reset) begin
         comparator_out <= 2'h0;
         flags <= 6'h00;
         left <= 8'h00;
      end else if (fire) begin
         left <= hold;
         if (which < 3'h2) begin
            comparator_out[which[0]] <= 1'b1;
         end else begin
            flags[which - 3'h2] <= 1'b1;
         end
      end else if (left == 8'h01) begin
         // Cleared so that the next event can rise again
         left <= 8'h00;
         comparator_out <= 2'h0;
         flags <= 6'h00;
      end else if (left != 8'h00) begin
         left <= left - 8'h01;
      end
   end
endmodule : trigger_source_model

// ### tb/test_dac_input_update_control.sv
module test_dac_input_update_control;
   timeunit 1ns;
   timeprecision 1ps;
   import dac_pkg::*;
   logic clk, reset, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr, hold;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] comparator_out;
   logic [5:0] flags;
   logic [DATA_W-1:0] converter_value, exp_v;
   logic converter_enable, analog_output_pin_enable, conversion_busy;
   logic fire;
   logic [2:0] which, sel;
   int err_total = 0;
   int checks = 0;
   int cycles = 0;

   dac_input_update_control dac_input_update_control_inst (
      .clk(clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .comparator_out(comparator_out),
      .ext_int0_flag(flags[0]), .timer0_compare_flag(flags[1]),
      .timer0_overflow_flag(flags[2]), .timer1_compare_b_flag(flags[3]),
      .timer1_overflow_flag(flags[4]), .timer1_capture_flag(flags[5]),
      .converter_value(converter_value),
      .converter_enable(converter_enable),
      .analog_output_pin_enable(analog_output_pin_enable),
      .conversion_busy(conversion_busy));

   trigger_source_model trigger_source_model_inst (
      .clk(clk), .reset(reset), .fire(fire), .which(which), .hold(hold),
      .comparator_out(comparator_out), .flags(flags));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task print_verdict;
      if (err_total == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         err_total++;
         print_verdict();
      end
   end

   task chk(input string what, input logic [31:0] exp,
            input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task rdchk(input string what, input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk(what, {24'h0, e}, rd);
   endtask : rdchk

   task trig(input logic [2:0] w, input logic [7:0] h, input int n);
      fire <= 1'b1;
      which <= w;
      hold <= h;
      @(posedge clk);
      fire <= 1'b0;
      repeat (n) @(posedge clk);
   endtask : trig

   task value_chk(input int n, input logic [DATA_W-1:0] e);
      repeat (n) @(posedge clk);
      chk("converter_value", e, converter_value);
   endtask : value_chk

   initial begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      fire = 1'b0;
      which = 3'h0;
      hold = 8'h00;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      rdchk("control", ADDR_CONTROL, CONTROL_RESET);
      rdchk("high", ADDR_HIGH, HIGH_RESET);
      rdchk("low", ADDR_LOW, LOW_RESET);
      apb(1'b0, 8'h10, 8'h00);
      chk("pslverr", 1, err);
      apb(1'b1, ADDR_CONTROL, 8'hff);
      rdchk("control", ADDR_CONTROL, CONTROL_MASK);
      apb(1'b1, ADDR_CONTROL, 8'h03);
      apb(1'b1, ADDR_LOW, 8'h5a);
      apb(1'b1, ADDR_HIGH, 8'h02);
      value_chk(3, 10'h25a);
      chk("busy", 1, conversion_busy);
      chk("enable", 1, converter_enable);
      chk("pin", 1, analog_output_pin_enable);
      apb(1'b1, ADDR_LOW, 8'hff);
      value_chk(3, 10'h25a);
      apb(1'b1, ADDR_HIGH, 8'h01);
      value_chk(3, 10'h1ff);
      apb(1'b1, ADDR_CONTROL, 8'h07);
      value_chk(3, 10'h1ff);
      apb(1'b1, ADDR_LOW, 8'h40);
      apb(1'b1, ADDR_HIGH, 8'hab);
      value_chk(3, 10'h2ad);
      rdchk("high", ADDR_HIGH, 8'hab);
      rdchk("low", ADDR_LOW, 8'h40);
      apb(1'b1, ADDR_CONTROL, 8'h05);
      repeat (3) @(posedge clk);
      chk("pin", 0, analog_output_pin_enable);
      apb(1'b1, ADDR_CONTROL, 8'h00);
      apb(1'b1, ADDR_HIGH, 8'h11);
      repeat (3) @(posedge clk);
      chk("enable", 0, converter_enable);
      chk("busy", 0, conversion_busy);
      // Both comparators flag on rising output
      apb(1'b1, ADDR_FLAGS, 8'h3c);
      exp_v = 10'h140;
      value_chk(0, exp_v);
      for (int s = 0; s < 8; s++) begin
         sel = s[2:0];
         apb(1'b1, ADDR_CONTROL, {1'b1, sel, 4'h5});
         apb(1'b1, ADDR_HIGH, {5'h10, sel});
         value_chk(3, exp_v);
         trig(sel + 3'h1, 8'h04, 12);
         value_chk(0, exp_v);
         apb(1'b1, ADDR_FLAGS, 8'h3f);
         trig(sel, 8'h04, 12);
         exp_v = {5'h10, sel, 2'b01};
         value_chk(0, exp_v);
         if (s < 2) begin
            apb(1'b0, ADDR_FLAGS, 8'h00);
            chk("cmp_flag", 1, rd[s]);
         end
         apb(1'b1, ADDR_FLAGS, 8'h3f);
         rdchk("flags", ADDR_FLAGS, 8'hbc);
         repeat (100) @(posedge clk);
         chk("busy", 0, conversion_busy);
      end
      apb(1'b1, ADDR_CONTROL, 8'ha5);
      apb(1'b1, ADDR_HIGH, 8'h10);
      trig(3'h2, 8'h05, 20);
      apb(1'b1, ADDR_HIGH, 8'h20);
      trig(3'h2, 8'h05, 100);
      value_chk(0, 10'h041);
      chk("busy", 0, conversion_busy);
      trig(3'h2, 8'hc8, 130);
      value_chk(0, 10'h081);
      chk("busy", 0, conversion_busy);
      repeat (80) @(posedge clk);
      apb(1'b1, ADDR_HIGH, 8'h30);
      trig(3'h2, 8'h05, 12);
      value_chk(0, 10'h0c1);
      repeat (100) @(posedge clk);
      apb(1'b1, ADDR_LOW, 8'hc0);
      trig(3'h2, 8'h05, 12);
      value_chk(0, 10'h0c1);
      apb(1'b1, ADDR_HIGH, 8'h40);
      trig(3'h2, 8'h05, 12);
      value_chk(0, 10'h103);
      // Comparator 0 on toggle, comparator 1 on falling output
      apb(1'b1, ADDR_FLAGS, 8'h23);
      trig(3'h0, 8'h04, 12);
      trig(3'h1, 8'h08, 3);
      rdchk("flags", ADDR_FLAGS, 8'ha1);
      repeat (12) @(posedge clk);
      rdchk("flags", ADDR_FLAGS, 8'ha3);
      print_verdict();
   end
endmodule : test_dac_input_update_control
